/* File: hbi_pkg.sv */
// Purpose: Shared constants for the 8-bit host bus port and its interrupt logic
// Assumes: Both ends run on clk at 250 MHz
// Notes: Function list below names what the device and host ends provide
//
// Function
// - Pending unmasked event raises interrupt line
// - Cause register names source; host reads it
// - Interrupt is a level until all serviced
// - New event during service keeps line high
// - Mask register write forces line low
// - Edge-triggered host rewrites mask after service
// - Masked source hidden from cause and line
// - Parallel host data path is eight bits
// - Latch pin level or toggling picks bus flavour
// - Latch pin edge forces multiplexed mode until reset
// - Multiplexed addresses even only, bit zero clear
// - Demux decode uses address lines plus bank bit
// - Bank one initialisation set, zero operational
// - Mode register reachable in either bank
// - Latch pin sampled during hardware reset
// - Hardware reset held four PCM clock periods
// - Hardware reset restores every register
package hbi_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int DW = 8;
  localparam int AW = 4;

  // ------------------------------------------------------------------
  // Device register indices and layout
  // ------------------------------------------------------------------
  localparam logic [3:0] IDX_CAUSE = 4'h0;
  localparam logic [3:0] IDX_MASK = 4'h1;
  localparam logic [3:0] IDX_SCRATCH = 4'h2;
  localparam logic [3:0] IDX_MODE = 4'hF;
  localparam int BANK_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'h01;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam int MUX_IDX_LSB = 1;
  localparam int MUX_BANK_POS = 5;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int PCM_CLK_NS = 488;
  localparam int RST_MIN_PCM_CLK = 4;
  localparam int RST_NS = RST_MIN_PCM_CLK * PCM_CLK_NS;
  localparam logic [9:0] RST_CYC = 10'((RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] ALE_CYC = 10'h002;
  localparam logic [9:0] STROBE_CYC = 10'h004;

  // ------------------------------------------------------------------
  // Host control registers (byte offsets) and fields
  // ------------------------------------------------------------------
  localparam logic [4:0] CSR_CTRL = 5'h00;
  localparam logic [4:0] CSR_ADDR = 5'h04;
  localparam logic [4:0] CSR_WDATA = 5'h08;
  localparam logic [4:0] CSR_RDATA = 5'h0C;
  localparam logic [4:0] CSR_STATUS = 5'h10;
  localparam logic [4:0] CSR_ISR = 5'h14;
  localparam logic [4:0] CSR_IMR = 5'h18;
  localparam int CTL_GO = 0;
  localparam int CTL_WRITE = 1;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_RESET = 4;
  localparam int ISR_DONE = 0;
  localparam int ISR_DEVIRQ = 1;
  localparam logic [1:0] HM_STROBE_DIR = 2'h0;
  localparam logic [1:0] HM_SPLIT = 2'h1;
  localparam logic [1:0] HM_MUX = 2'h2;
  localparam logic [1:0] HMODE_RST = 2'h1;

endpackage

/* File: hbi_if.sv */
// Purpose: Pin bundle between host end and device end
// Assumes: Both ends on the same clk
// Notes: Resolves the shared data bus from the two drive enables
`timescale 1ns/1ps
interface hbi_if;
  logic hw_clear_pin;
  logic ale;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [3:0] addr;
  logic [7:0] hd;
  logic hd_oe;
  logic [7:0] dd;
  logic dd_oe;
  logic irq;
  logic [7:0] data;

  // Undriven bus floats high
  assign data = hd_oe ? hd : (dd_oe ? dd : 8'hFF);

  modport dev (
    input hw_clear_pin, ale, cs_n, rd_n, wr_n, addr, data,
    output dd, dd_oe, irq
  );
  modport host (
    output hw_clear_pin, ale, cs_n, rd_n, wr_n, addr, hd, hd_oe,
    input data, irq
  );
endinterface // hbi_if

/* File: hbi_device.sv */
// Purpose: Device end: 8-bit host port, register banks, interrupt request
// Assumes: Host pins come from logic on clk, so no synchroniser
// Notes: rd_n doubles as data strobe and wr_n as read/write in strobe mode
`timescale 1ns/1ps
module hbi_device (
  input wire logic clk,
  input wire logic sys_rst,
  hbi_if.dev bus,
  input wire logic [7:0] event_in,
  output logic bank_sel,
  output logic mux_mode,
  output logic [7:0] oper_reg,
  output logic [7:0] init_reg
);

  // ------------------------------------------------------------------
  // Reset and bus flavour
  // ------------------------------------------------------------------
  logic rst;
  logic strap_ff;
  logic mux_ff;
  logic ale_prev_ff;

  // Pin reset and system reset act alike
  assign rst = sys_rst | bus.hw_clear_pin;

  always_ff @(posedge clk) begin
    ale_prev_ff <= bus.ale;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_ff <= bus.ale;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mux_ff <= 1'b0;
    end else if (bus.ale != ale_prev_ff) begin
      // Sticky: only a reset leaves multiplexed mode
      mux_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  logic strobe_dir;
  logic rd_act;
  logic wr_act;
  logic wr_prev_ff;
  logic wr_pulse;
  logic [7:0] mux_adr_ff;
  logic [3:0] idx;
  logic bank;
  logic adr_ok;
  logic sel_cause;
  logic sel_mask;
  logic sel_oper;
  logic sel_init;
  logic sel_mode;
  logic [7:0] mode_ff;

  // Level on latch pin at reset picks strobe+direction or split strobes
  assign strobe_dir = strap_ff & ~mux_ff;

  always_comb begin
    if (strobe_dir) begin
      rd_act = ~bus.cs_n & ~bus.rd_n & bus.wr_n;
      wr_act = ~bus.cs_n & ~bus.rd_n & ~bus.wr_n;
    end else begin
      rd_act = ~bus.cs_n & ~bus.rd_n;
      wr_act = ~bus.cs_n & ~bus.wr_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_prev_ff <= 1'b0;
    end else begin
      wr_prev_ff <= wr_act;
    end
  end

  // Commit once per strobe, on its first cycle
  assign wr_pulse = wr_act & ~wr_prev_ff;

  // Address rides on the data lines while the latch pin is high
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_adr_ff <= 8'h00;
    end else if (bus.ale) begin
      mux_adr_ff <= bus.data;
    end
  end

  always_comb begin
    if (mux_ff) begin
      idx = mux_adr_ff[hbi_pkg::MUX_IDX_LSB +: hbi_pkg::AW];
      bank = mux_adr_ff[hbi_pkg::MUX_BANK_POS];
      // Odd or out-of-range addresses hit nothing
      adr_ok = ~mux_adr_ff[0] & (mux_adr_ff[7:6] == 2'h0);
    end else begin
      idx = bus.addr;
      bank = mode_ff[hbi_pkg::BANK_BIT];
      adr_ok = 1'b1;
    end
  end

  always_comb begin
    sel_mode = adr_ok & (idx == hbi_pkg::IDX_MODE);
    sel_cause = adr_ok & ~bank & (idx == hbi_pkg::IDX_CAUSE);
    sel_mask = adr_ok & ~bank & (idx == hbi_pkg::IDX_MASK);
    sel_oper = adr_ok & ~bank & (idx == hbi_pkg::IDX_SCRATCH);
    sel_init = adr_ok & bank & (idx == hbi_pkg::IDX_SCRATCH);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0] mask_ff;
  logic [7:0] oper_ff;
  logic [7:0] init_ff;
  logic [7:0] cause_ff;
  logic [7:0] cause_set;
  logic [7:0] cause_clr;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= hbi_pkg::MODE_RST;
    end else if (wr_pulse && sel_mode) begin
      mode_ff <= bus.data & hbi_pkg::MODE_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= hbi_pkg::MASK_RST;
    end else if (wr_pulse && sel_mask) begin
      mask_ff <= bus.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oper_ff <= hbi_pkg::SCRATCH_RST;
    end else if (wr_pulse && sel_oper) begin
      oper_ff <= bus.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      init_ff <= hbi_pkg::SCRATCH_RST;
    end else if (wr_pulse && sel_init) begin
      init_ff <= bus.data;
    end
  end

  // Masked sources never latch a cause bit
  assign cause_set = event_in & ~mask_ff;
  assign cause_clr = (wr_pulse && sel_cause) ? bus.data : 8'h00;

  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_ff <= hbi_pkg::CAUSE_RST;
    end else begin
      cause_ff <= (cause_ff & ~cause_clr) | cause_set;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------------
  logic irq_ff;

  // Line follows the whole pending set, so a fresh bit keeps it high
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (wr_act && sel_mask) begin
      // Low for the full mask write; lags strobe by one clock
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(cause_ff & ~mask_ff);
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] dd_ff;
  logic dd_oe_ff;

  always_comb begin
    rd_mux = 8'h00;
    if (sel_mode) begin
      rd_mux = mode_ff;
    end else if (sel_cause) begin
      rd_mux = cause_ff & ~mask_ff;
    end else if (sel_mask) begin
      rd_mux = mask_ff;
    end else if (sel_oper) begin
      rd_mux = oper_ff;
    end else if (sel_init) begin
      rd_mux = init_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dd_ff <= 8'h00;
      dd_oe_ff <= 1'b0;
    end else begin
      dd_ff <= rd_mux;
      dd_oe_ff <= rd_act;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign bus.dd = dd_ff;
  assign bus.dd_oe = dd_oe_ff;
  assign bus.irq = irq_ff;
  assign bank_sel = mode_ff[hbi_pkg::BANK_BIT];
  assign mux_mode = mux_ff;
  assign oper_reg = oper_ff;
  assign init_reg = init_ff;

endmodule // hbi_device

/* File: hbi_host.sv */
// Purpose: Host end: drives the 8-bit port on orders from Avalon-MM registers
// Assumes: Software serialises commands; busy is polled or done interrupt used
// Notes: Bank bit of the address register is used only in multiplexed mode
`timescale 1ns/1ps
module hbi_host (
  input wire logic clk,
  input wire logic sys_rst,
  hbi_if.host bus,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  typedef enum {H_IDLE, H_RST, H_ALE, H_ALE_LO, H_SETUP, H_STROBE, H_HOLD} host_state_t;

  host_state_t state_ff;
  logic [9:0] cnt_ff;
  logic [1:0] hmode_ff;
  logic [4:0] adr_ff;
  logic [7:0] wdat_ff;
  logic [7:0] rdat_ff;
  logic wr_cmd_ff;
  logic [1:0] isr_ff;
  logic [1:0] imr_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic irq_prev_ff;
  logic acc_wr;
  logic go;
  logic done;

  // ------------------------------------------------------------------
  // Avalon slave: one wait cycle, then taken
  // ------------------------------------------------------------------
  assign acc_wr = avs_write & ~wait_ff;
  assign go = acc_wr & (avs_address == hbi_pkg::CSR_CTRL) & avs_writedata[hbi_pkg::CTL_GO]
    & (state_ff == H_IDLE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && wait_ff) begin
      case (avs_address)
        hbi_pkg::CSR_CTRL: rdata_ff <= {28'h0, hmode_ff, wr_cmd_ff, 1'b0};
        hbi_pkg::CSR_ADDR: rdata_ff <= {27'h0, adr_ff};
        hbi_pkg::CSR_WDATA: rdata_ff <= {24'h0, wdat_ff};
        hbi_pkg::CSR_RDATA: rdata_ff <= {24'h0, rdat_ff};
        hbi_pkg::CSR_STATUS: rdata_ff <= {30'h0, bus.irq, state_ff != H_IDLE};
        hbi_pkg::CSR_ISR: rdata_ff <= {30'h0, isr_ff};
        hbi_pkg::CSR_IMR: rdata_ff <= {30'h0, imr_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hmode_ff <= hbi_pkg::HMODE_RST;
      wr_cmd_ff <= 1'b0;
    end else if (go) begin
      hmode_ff <= avs_writedata[hbi_pkg::CTL_MODE_LSB +: 2];
      wr_cmd_ff <= avs_writedata[hbi_pkg::CTL_WRITE];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adr_ff <= 5'h00;
      wdat_ff <= 8'h00;
      imr_ff <= 2'h0;
    end else if (acc_wr) begin
      if (avs_address == hbi_pkg::CSR_ADDR) begin
        adr_ff <= avs_writedata[4:0];
      end
      if (avs_address == hbi_pkg::CSR_WDATA) begin
        wdat_ff <= avs_writedata[7:0];
      end
      if (avs_address == hbi_pkg::CSR_IMR) begin
        imr_ff <= avs_writedata[1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Bus cycle sequencer
  // ------------------------------------------------------------------
  assign done = ((state_ff == H_RST) || (state_ff == H_HOLD)) && (cnt_ff == 10'h000);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= H_IDLE;
      cnt_ff <= 10'h000;
    end else begin
      case (state_ff)
        H_IDLE: begin
          if (go && avs_writedata[hbi_pkg::CTL_RESET]) begin
            state_ff <= H_RST;
            cnt_ff <= hbi_pkg::RST_CYC - 10'h001;
          end else if (go && avs_writedata[hbi_pkg::CTL_MODE_LSB +: 2] == hbi_pkg::HM_MUX) begin
            state_ff <= H_ALE;
            cnt_ff <= hbi_pkg::ALE_CYC - 10'h001;
          end else if (go) begin
            state_ff <= H_SETUP;
          end
        end
        H_RST, H_ALE, H_STROBE: begin
          if (cnt_ff != 10'h000) begin
            cnt_ff <= cnt_ff - 10'h001;
          end else if (state_ff == H_ALE) begin
            state_ff <= H_ALE_LO;
          end else if (state_ff == H_STROBE) begin
            state_ff <= H_HOLD;
          end else begin
            state_ff <= H_IDLE;
          end
        end
        H_ALE_LO: state_ff <= H_SETUP;
        H_SETUP: begin
          state_ff <= H_STROBE;
          cnt_ff <= hbi_pkg::STROBE_CYC - 10'h001;
        end
        H_HOLD: state_ff <= H_IDLE;
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  // Pins are registered copies of the state, one clock behind it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.hw_clear_pin <= 1'b0;
      bus.ale <= 1'b0;
      bus.cs_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.addr <= 4'h0;
      bus.hd <= 8'h00;
      bus.hd_oe <= 1'b0;
    end else begin
      bus.hw_clear_pin <= (state_ff == H_RST);
      // Fixed level picks a demux flavour, toggling picks multiplexed
      if (hmode_ff == hbi_pkg::HM_MUX) begin
        bus.ale <= (state_ff == H_ALE);
      end else begin
        bus.ale <= (hmode_ff == hbi_pkg::HM_STROBE_DIR);
      end
      bus.cs_n <= ~((state_ff == H_SETUP) || (state_ff == H_STROBE) || (state_ff == H_HOLD));
      bus.addr <= adr_ff[3:0];
      if (hmode_ff == hbi_pkg::HM_STROBE_DIR) begin
        bus.rd_n <= ~(state_ff == H_STROBE);
        bus.wr_n <= ~(wr_cmd_ff && state_ff != H_IDLE && state_ff != H_RST);
      end else begin
        bus.rd_n <= ~(state_ff == H_STROBE && !wr_cmd_ff);
        bus.wr_n <= ~(state_ff == H_STROBE && wr_cmd_ff);
      end
      if (state_ff == H_ALE) begin
        bus.hd <= {2'h0, adr_ff[4], adr_ff[3:0], 1'b0};
        bus.hd_oe <= 1'b1;
      end else begin
        bus.hd <= wdat_ff;
        bus.hd_oe <= wr_cmd_ff && (state_ff == H_SETUP || state_ff == H_STROBE
          || state_ff == H_HOLD);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdat_ff <= 8'h00;
    end else if (state_ff == H_HOLD && !wr_cmd_ff) begin
      // Cause register read tells software which source fired
      rdat_ff <= bus.data;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_prev_ff <= 1'b0;
    end else begin
      irq_prev_ff <= bus.irq;
    end
  end

  // Rise-only detect: software must rewrite the mask to see a re-arm
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      isr_ff <= 2'h0;
    end else begin
      isr_ff <= (isr_ff & ~((acc_wr && avs_address == hbi_pkg::CSR_ISR) ? avs_writedata[1:0]
        : 2'h0)) | {bus.irq & ~irq_prev_ff, done};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(isr_ff & imr_ff);
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq = irq_ff;

endmodule // hbi_host

/* File: host_bus_interrupt_port_properties.sv */
// Purpose: Concurrent checks on the host port pins and the interrupt line
// Assumes: All pins change on clk; sys_rst synchronous, active high
// Notes: Flavour and bank are tracked from the pins to spot mask writes
`timescale 1ns/1ps
module host_bus_interrupt_port_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hw_clear_pin,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] hd,
  input wire logic hd_oe,
  input wire logic dd_oe,
  input wire logic [7:0] data,
  input wire logic irq
);
  // ------------------------------------------------------------------
  // Pin decode
  // ------------------------------------------------------------------
  logic mux_ff;
  logic bank_ff;
  logic [9:0] clr_cnt_ff;
  logic rd_strb;
  logic wr_strb;
  logic mask_wr;

  // With ale high rd_n is the data strobe and wr_n the direction
  assign rd_strb = !cs_n && !rd_n && wr_n;
  assign wr_strb = !cs_n && !wr_n && (ale ? !rd_n : rd_n);
  // Mux accesses are left out: their index travels on the data bus
  assign mask_wr = wr_strb && !mux_ff && !bank_ff && !hw_clear_pin
                   && addr == hbi_pkg::IDX_MASK;

  always_ff @(posedge clk) begin
    if (sys_rst || hw_clear_pin) begin
      mux_ff <= 1'b0;
    end else if (ale != $past(ale)) begin
      mux_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || hw_clear_pin) begin
      bank_ff <= 1'b0;
    end else if (wr_strb && !mux_ff && addr == hbi_pkg::IDX_MODE) begin
      bank_ff <= data[hbi_pkg::BANK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !hw_clear_pin) begin
      clr_cnt_ff <= 10'h000;
    end else if (clr_cnt_ff != 10'h3FF) begin
      clr_cnt_ff <= clr_cnt_ff + 10'h001;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_MASK_WR_QUIET: assert property (mask_wr |=> !irq)
    else $error("irq high during mask write");
  AST_IRQ_HOLD: assert property (irq && cs_n && !hw_clear_pin |=> irq)
    else $error("irq dropped with no access");
  AST_CLEAR_QUIET: assert property (hw_clear_pin |=> !irq && !dd_oe)
    else $error("device active in hardware reset");
  AST_READ_DRIVE: assert property (rd_strb && !hw_clear_pin |=> dd_oe)
    else $error("read strobe not answered");
  AST_READ_RELEASE: assert property (!rd_strb |=> !dd_oe)
    else $error("device drives bus outside read");
  AST_ONE_DRIVER: assert property (!(hd_oe && dd_oe))
    else $error("both ends drive data");
  AST_MUX_EVEN: assert property (mux_ff && ale && hd_oe |-> !hd[0] && hd[7:6] == 2'h0)
    else $error("odd mux address");
  AST_CLEAR_LEN: assert property ($fell(hw_clear_pin) |-> clr_cnt_ff >= hbi_pkg::RST_CYC)
    else $error("hardware reset too short");
endmodule // host_bus_interrupt_port_properties

/* File: test_host_bus_interrupt_port.sv */
// Purpose: Drives the host end over Avalon-MM, device end faces it on the pins
// Assumes: Both ends on clk at 250 MHz
// Notes: One idle cycle after each Avalon transfer keeps drives apart
`timescale 1ns/1ps
module test_host_bus_interrupt_port;
  typedef struct packed {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [7:0] event_in = 8'h00;
  logic bank_sel;
  logic mux_mode;
  logic [7:0] oper_reg;
  logic [7:0] init_reg;
  logic [31:0] q;
  logic [1:0] mode = hbi_pkg::HMODE_RST;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  row_t rows [11] = '{
    '{1'b1, 5'h02, 8'h5A, 8'h00}, '{1'b0, 5'h02, 8'h00, 8'h5A}, '{1'b1, 5'h0F, 8'h01, 8'h00},
    '{1'b0, 5'h0F, 8'h00, 8'h01}, '{1'b1, 5'h02, 8'hA5, 8'h00}, '{1'b0, 5'h02, 8'h00, 8'hA5},
    '{1'b0, 5'h00, 8'h00, 8'h00}, '{1'b1, 5'h0F, 8'h00, 8'h00}, '{1'b0, 5'h02, 8'h00, 8'h5A},
    '{1'b0, 5'h03, 8'h00, 8'h00}, '{1'b0, 5'h0F, 8'h00, 8'h00}};

  // ------------------------------------------------------------------
  // Design
  // ------------------------------------------------------------------
  hbi_if i_hbi_if ();
  hbi_device i_hbi_device (.clk(clk), .sys_rst(sys_rst), .bus(i_hbi_if),
    .event_in(event_in), .bank_sel(bank_sel), .mux_mode(mux_mode),
    .oper_reg(oper_reg), .init_reg(init_reg));
  hbi_host i_hbi_host (.clk(clk), .sys_rst(sys_rst), .bus(i_hbi_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  host_bus_interrupt_port_properties i_host_bus_interrupt_port_properties (
    .clk(clk), .sys_rst(sys_rst), .hw_clear_pin(i_hbi_if.hw_clear_pin),
    .ale(i_hbi_if.ale), .cs_n(i_hbi_if.cs_n), .rd_n(i_hbi_if.rd_n),
    .wr_n(i_hbi_if.wr_n), .addr(i_hbi_if.addr), .hd(i_hbi_if.hd),
    .hd_oe(i_hbi_if.hd_oe), .dd_oe(i_hbi_if.dd_oe), .data(i_hbi_if.data),
    .irq(i_hbi_if.irq));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle();
    do av(1'b0, hbi_pkg::CSR_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask

  task automatic dev(input logic w, input logic [4:0] a, input logic [7:0] d);
    av(1'b1, hbi_pkg::CSR_ADDR, {27'h0, a});
    av(1'b1, hbi_pkg::CSR_WDATA, {24'h0, d});
    av(1'b1, hbi_pkg::CSR_CTRL, {27'h0, 1'b0, mode, w, 1'b1});
    idle();
    av(1'b0, hbi_pkg::CSR_RDATA, 32'h0);
  endtask

  task automatic hwrst(input logic [1:0] m);
    mode = m;
    av(1'b1, hbi_pkg::CSR_CTRL, {27'h0, 1'b1, m, 1'b0, 1'b1});
    idle();
  endtask

  task automatic pulse(input logic [7:0] e);
    event_in <= e;
    @(posedge clk);
    event_in <= 8'h00;
    @(posedge clk);
    // Cause flop, then irq flop: line is settled only one edge later
    @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    av(1'b0, hbi_pkg::CSR_STATUS, 32'h0);
    chk(q, 32'h0);
    chk({mux_mode, bank_sel, i_hbi_if.irq, oper_reg, init_reg}, 32'h0);
    av(1'b1, 5'h1C, 32'hFF);
    av(1'b0, 5'h1C, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      dev(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q[7:0], rows[i].e);
    end
    chk({oper_reg, init_reg, bank_sel}, {8'h5A, 8'hA5, 1'b0});
    $display("test banks done");
    av(1'b1, hbi_pkg::CSR_IMR, 32'h3);
    pulse(8'h08);
    chk(i_hbi_if.irq, 1'b1);
    dev(1'b0, 5'h00, 8'h00);
    chk(q[7:0], 8'h08);
    pulse(8'h20);
    dev(1'b1, 5'h00, 8'h08);
    chk(i_hbi_if.irq, 1'b1);
    dev(1'b0, 5'h00, 8'h00);
    chk(q[7:0], 8'h20);
    dev(1'b1, 5'h00, 8'h20);
    chk(i_hbi_if.irq, 1'b0);
    dev(1'b1, 5'h01, 8'h01);
    pulse(8'h03);
    dev(1'b0, 5'h00, 8'h00);
    chk(q[7:0], 8'h02);
    av(1'b1, hbi_pkg::CSR_ISR, 32'h3);
    av(1'b0, hbi_pkg::CSR_ISR, 32'h0);
    chk(q[1], 1'b0);
    dev(1'b1, 5'h01, 8'h01);
    av(1'b0, hbi_pkg::CSR_ISR, 32'h0);
    chk(q[1], 1'b1);
    chk(irq, 1'b1);
    av(1'b1, hbi_pkg::CSR_IMR, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    av(1'b1, hbi_pkg::CSR_IMR, 32'h3);
    av(1'b1, hbi_pkg::CSR_ISR, 32'h3);
    @(posedge clk);
    chk(irq, 1'b0);
    dev(1'b1, 5'h00, 8'h02);
    $display("test interrupt done");
    hwrst(hbi_pkg::HM_STROBE_DIR);
    chk({mux_mode, bank_sel}, 2'h0);
    dev(1'b1, 5'h02, 8'h3C);
    dev(1'b0, 5'h02, 8'h00);
    chk(q[7:0], 8'h3C);
    dev(1'b0, 5'h01, 8'h00);
    chk(q[7:0], hbi_pkg::MASK_RST);
    $display("test strobe done");
    mode = hbi_pkg::HM_MUX;
    dev(1'b0, 5'h02, 8'h00);
    chk({mux_mode, q[7:0]}, {1'b1, 8'h3C});
    dev(1'b0, 5'h12, 8'h00);
    chk(q[7:0], hbi_pkg::SCRATCH_RST);
    mode = hbi_pkg::HM_SPLIT;
    dev(1'b0, 5'h02, 8'h00);
    chk(mux_mode, 1'b1);
    hwrst(hbi_pkg::HM_SPLIT);
    chk(mux_mode, 1'b0);
    dev(1'b0, 5'h02, 8'h00);
    chk({oper_reg, q[7:0]}, {hbi_pkg::SCRATCH_RST, hbi_pkg::SCRATCH_RST});
    $display("test mux done");
    finish_test();
  end
endmodule // test_host_bus_interrupt_port
